// file: sdcb_pkg.sv
// Shared constants and types for the DRAM clock-enable and bank-state logic.
// Assumes one 250 MHz clock shared by controller and device ends.
package sdcb_pkg;
  localparam int unsigned SDCB_CLK_PERIOD_NS = 4;
  // Row cycle time and clock-enable setup interval, in ns
  localparam int unsigned SDCB_ROW_CYCLE_TIME_NS = 60;
  localparam int unsigned SDCB_CKE_SETUP_NS = 8;
  localparam int unsigned SDCB_ROW_CYCLE_CYC =
    (SDCB_ROW_CYCLE_TIME_NS + SDCB_CLK_PERIOD_NS - 1) / SDCB_CLK_PERIOD_NS;
  localparam int unsigned SDCB_CKE_SETUP_CYC =
    (SDCB_CKE_SETUP_NS + SDCB_CLK_PERIOD_NS - 1) / SDCB_CLK_PERIOD_NS;
  // Cycles to wait after a mode register load
  localparam int unsigned SDCB_MODE_LOAD_WAIT_CYC = 2;
  // Burst length counted by the device for auto-precharge
  localparam int unsigned SDCB_BURST_CYC = 4;
  localparam int unsigned SDCB_ADDR_W = 12;
  localparam int unsigned SDCB_BANK_BIT = 11;
  localparam int unsigned SDCB_AP_BIT = 10;
  localparam int unsigned SDCB_CNT_W = 8;

  typedef enum logic [2:0] {
    SDCB_BK_IDLE, SDCB_BK_ACTIVE, SDCB_BK_READ, SDCB_BK_WRITE,
    SDCB_BK_READ_AP, SDCB_BK_WRITE_AP
  } sdcb_bank_e;

  typedef enum logic [2:0] {
    SDCB_MD_NORMAL, SDCB_MD_SELF_REFRESH, SDCB_MD_SR_RECOVERY,
    SDCB_MD_POWER_DOWN, SDCB_MD_SUSPEND
  } sdcb_mode_e;

  // Commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] SDCB_CMD_NOP = 4'h7;
  localparam logic [3:0] SDCB_CMD_BST = 4'h6;
  localparam logic [3:0] SDCB_CMD_READ = 4'h5;
  localparam logic [3:0] SDCB_CMD_WRITE = 4'h4;
  localparam logic [3:0] SDCB_CMD_ACT = 4'h3;
  localparam logic [3:0] SDCB_CMD_PRE = 4'h2;
  localparam logic [3:0] SDCB_CMD_REF = 4'h1;
  localparam logic [3:0] SDCB_CMD_MRS = 4'h0;
  localparam logic [3:0] SDCB_CMD_DESELECT_COMMAND = 4'h8;

  // Controller request codes
  typedef enum logic [3:0] {
    SDCB_RQ_NONE, SDCB_RQ_ACT, SDCB_RQ_READ, SDCB_RQ_WRITE, SDCB_RQ_PRE,
    SDCB_RQ_BST, SDCB_RQ_REF, SDCB_RQ_MRS, SDCB_RQ_SELF_REFRESH,
    SDCB_RQ_POWER_DOWN, SDCB_RQ_SUSPEND, SDCB_RQ_WAKE
  } sdcb_req_e;
endpackage : sdcb_pkg

// file: sdcb_if.sv
// Pin bundle between the memory controller and the DRAM device logic.
// Both ends share i_clk_sys; the testbench instantiates and joins them.
`timescale 1ns/1ns
interface sdcb_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [11:0] addr;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, addr);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, addr);
endinterface : sdcb_if

// file: sdcb_device.sv
// DRAM device end: clock-enable mode tracking and per-bank state machines.
// Assumes pins come from controller logic on the same clock (no synchroniser).
`timescale 1ns/1ns
module sdcb_device
  import sdcb_pkg::*;
#(
  parameter int unsigned BURST_CYC = SDCB_BURST_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  sdcb_if.dev pins,
  output logic [2:0] o_bank0_state,
  output logic [2:0] o_bank1_state,
  output logic [2:0] o_mode,
  output logic o_frozen,
  output logic o_illegal,
  output logic o_refresh_pulse,
  output logic [11:0] o_mode_reg
);
  typedef struct packed {
    logic cke_prev;
    sdcb_mode_e mode;
    sdcb_bank_e [1:0] bank;
    logic [1:0][SDCB_CNT_W-1:0] burst_cnt;
    logic [SDCB_CNT_W-1:0] rec_cnt;
    logic illegal;
    logic refresh;
    logic [11:0] mode_reg;
    logic frozen;
  } sdcb_dev_s;

  sdcb_dev_s st_q, st_d;
  logic [3:0] cmd;
  logic bsel;
  logic ap;
  logic ras_or_cas_low;

  assign cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  assign bsel = pins.addr[SDCB_BANK_BIT];
  assign ap = pins.addr[SDCB_AP_BIT];
  assign ras_or_cas_low = !pins.cs_n && (!pins.ras_n || !pins.cas_n);

  always_comb begin
    logic both_idle;
    logic is_nop;
    st_d = st_q;
    both_idle = (st_q.bank[0] == SDCB_BK_IDLE) && (st_q.bank[1] == SDCB_BK_IDLE);
    is_nop = pins.cs_n || (cmd == SDCB_CMD_NOP);
    st_d.cke_prev = pins.cke;
    st_d.illegal = 1'b0;
    st_d.refresh = 1'b0;
    case (st_q.mode)
      SDCB_MD_SELF_REFRESH: begin
        if (!st_q.cke_prev && pins.cke) begin
          // Recovery starts; the wake edge itself must carry no strobe
          st_d.mode = SDCB_MD_SR_RECOVERY;
          st_d.rec_cnt = SDCB_CNT_W'(SDCB_ROW_CYCLE_CYC);
          st_d.illegal = ras_or_cas_low;
        end
      end
      SDCB_MD_SR_RECOVERY: begin
        if (st_q.cke_prev && !pins.cke) begin
          if (is_nop) begin
            st_d.mode = SDCB_MD_POWER_DOWN;
          end else begin
            st_d.illegal = 1'b1;
          end
        end else if (st_q.cke_prev && pins.cke) begin
          st_d.illegal = ras_or_cas_low;
          if (st_q.rec_cnt <= SDCB_CNT_W'(1)) begin
            st_d.mode = SDCB_MD_NORMAL;
            st_d.rec_cnt = '0;
          end else begin
            st_d.rec_cnt = st_q.rec_cnt - SDCB_CNT_W'(1);
          end
        end
      end
      SDCB_MD_POWER_DOWN: begin
        // Pins other than enable are ignored here, wake needs no command
        if (!st_q.cke_prev && pins.cke) begin
          st_d.mode = SDCB_MD_NORMAL;
        end
      end
      SDCB_MD_SUSPEND: begin
        if (!st_q.cke_prev && pins.cke) begin
          st_d.mode = SDCB_MD_NORMAL;
        end
      end
      default: begin
        if (both_idle && st_q.cke_prev && !pins.cke) begin
          if (cmd == SDCB_CMD_REF) begin
            st_d.mode = SDCB_MD_SELF_REFRESH;
          end else begin
            st_d.mode = SDCB_MD_POWER_DOWN;
          end
        end else if (!both_idle && st_q.cke_prev && !pins.cke) begin
          // This cycle's command still executes, freeze from next
          st_d.mode = SDCB_MD_SUSPEND;
        end
        if (st_q.cke_prev) begin
          for (int b = 0; b < 2; b++) begin
            // Auto-precharge bursts count down and self-precharge
            if ((st_q.bank[b] == SDCB_BK_READ_AP) || (st_q.bank[b] == SDCB_BK_WRITE_AP)) begin
              if (st_q.burst_cnt[b] <= SDCB_CNT_W'(1)) begin
                st_d.bank[b] = SDCB_BK_IDLE;
              end else begin
                st_d.burst_cnt[b] = st_q.burst_cnt[b] - SDCB_CNT_W'(1);
              end
            end
          end
          if (!pins.cs_n && !(both_idle && !pins.cke)) begin
            case (cmd)
              SDCB_CMD_ACT: begin
                if (st_q.bank[bsel] == SDCB_BK_IDLE) begin
                  st_d.bank[bsel] = SDCB_BK_ACTIVE;
                end else begin
                  st_d.illegal = 1'b1;
                end
              end
              SDCB_CMD_READ, SDCB_CMD_WRITE: begin
                if (st_q.bank[bsel] == SDCB_BK_IDLE) begin
                  st_d.illegal = 1'b1;
                end else if (ap) begin
                  st_d.bank[bsel] = (cmd == SDCB_CMD_READ) ? SDCB_BK_READ_AP : SDCB_BK_WRITE_AP;
                  st_d.burst_cnt[bsel] = SDCB_CNT_W'(BURST_CYC);
                end else begin
                  st_d.bank[bsel] = (cmd == SDCB_CMD_READ) ? SDCB_BK_READ : SDCB_BK_WRITE;
                end
              end
              SDCB_CMD_BST: begin
                if ((st_q.bank[bsel] == SDCB_BK_READ) || (st_q.bank[bsel] == SDCB_BK_WRITE)) begin
                  st_d.bank[bsel] = SDCB_BK_ACTIVE;
                end
              end
              SDCB_CMD_PRE: begin
                if (ap) begin
                  st_d.bank[0] = SDCB_BK_IDLE;
                  st_d.bank[1] = SDCB_BK_IDLE;
                end else begin
                  st_d.bank[bsel] = SDCB_BK_IDLE;
                end
              end
              SDCB_CMD_REF: begin
                if (both_idle) begin
                  st_d.refresh = 1'b1;
                end else begin
                  st_d.illegal = 1'b1;
                end
              end
              SDCB_CMD_MRS: begin
                if (both_idle) begin
                  st_d.mode_reg = pins.addr;
                end else begin
                  st_d.illegal = 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
    endcase
    // Frozen is kept as a register so the output is a flop, not a decode
    // It follows the next mode, so it lines up with o_mode on the same edge
    st_d.frozen = (st_d.mode != SDCB_MD_NORMAL);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      // Enum fields take their idle encodings explicitly, not by zero fill
      st_q <= '0;
      st_q.mode <= SDCB_MD_NORMAL;
      st_q.bank <= '{SDCB_BK_IDLE, SDCB_BK_IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  // All outputs below are plain register taps
  assign o_bank0_state = st_q.bank[0];
  assign o_bank1_state = st_q.bank[1];
  assign o_mode = st_q.mode;
  assign o_frozen = st_q.frozen;
  assign o_illegal = st_q.illegal;
  assign o_refresh_pulse = st_q.refresh;
  assign o_mode_reg = st_q.mode_reg;
endmodule : sdcb_device

// file: sdcb_ctrl.sv
// Controller end: turns one-cycle requests into pin commands and enable moves.
// Assumes the user keeps banks idle before low-power requests.
`timescale 1ns/1ns
module sdcb_ctrl
  import sdcb_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_req,
  input wire logic [11:0] i_addr,
  output logic o_busy,
  sdcb_if.ctrl pins
);
  typedef struct packed {
    logic cke;
    logic [3:0] cmd;
    logic [11:0] addr;
    logic low_power;
    logic [SDCB_CNT_W-1:0] wait_cnt;
  } sdcb_ctrl_s;

  sdcb_ctrl_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.cmd = SDCB_CMD_NOP;
    if (st_q.wait_cnt != '0) begin
      // Only no-operation while a mode load, wake or recovery settles
      st_d.wait_cnt = st_q.wait_cnt - SDCB_CNT_W'(1);
    end else if (st_q.low_power || !st_q.cke) begin
      if (sdcb_req_e'(i_req) == SDCB_RQ_WAKE) begin
        st_d.cke = 1'b1;
        st_d.low_power = 1'b0;
        st_d.wait_cnt = SDCB_CNT_W'(st_q.low_power ? SDCB_ROW_CYCLE_CYC : SDCB_CKE_SETUP_CYC);
      end
    end else begin
      st_d.addr = i_addr;
      case (sdcb_req_e'(i_req))
        SDCB_RQ_ACT: st_d.cmd = SDCB_CMD_ACT;
        SDCB_RQ_READ: st_d.cmd = SDCB_CMD_READ;
        SDCB_RQ_WRITE: st_d.cmd = SDCB_CMD_WRITE;
        SDCB_RQ_PRE: st_d.cmd = SDCB_CMD_PRE;
        SDCB_RQ_BST: st_d.cmd = SDCB_CMD_BST;
        SDCB_RQ_REF: st_d.cmd = SDCB_CMD_REF;
        SDCB_RQ_MRS: begin
          st_d.cmd = SDCB_CMD_MRS;
          st_d.wait_cnt = SDCB_CNT_W'(SDCB_MODE_LOAD_WAIT_CYC);
        end
        SDCB_RQ_SELF_REFRESH: begin
          st_d.cmd = SDCB_CMD_REF;
          st_d.cke = 1'b0;
          st_d.low_power = 1'b1;
        end
        SDCB_RQ_POWER_DOWN: begin
          st_d.cke = 1'b0;
        end
        SDCB_RQ_SUSPEND: begin
          st_d.cke = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_q <= '0;
      st_q.cke <= 1'b1;
      st_q.cmd <= SDCB_CMD_NOP;
    end else begin
      st_q <= st_d;
    end
  end

  assign pins.cke = st_q.cke;
  assign pins.cs_n = st_q.cmd[3];
  assign pins.ras_n = st_q.cmd[2];
  assign pins.cas_n = st_q.cmd[1];
  assign pins.we_n = st_q.cmd[0];
  assign pins.addr = st_q.addr;
  assign o_busy = (st_q.wait_cnt != '0) || !st_q.cke || st_q.low_power;
endmodule : sdcb_ctrl

// file: sdcb_pins_sva.sv
// Checker: properties on the shared pins and the device state outputs.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ns
module sdcb_pins_sva
  import sdcb_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic [2:0] o_bank0_state,
  input wire logic [2:0] o_bank1_state,
  input wire logic [2:0] o_mode,
  input wire logic o_refresh_pulse,
  input wire logic [11:0] o_mode_reg
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic [3:0] cmd;
  logic nrm, idl, lo0, lo1;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign nrm = o_mode == SDCB_MD_NORMAL;
  assign idl = o_bank0_state == SDCB_BK_IDLE && o_bank1_state == SDCB_BK_IDLE;
  // Auto-precharge states may change on their own, so they are left out here
  assign lo0 = o_bank0_state inside {SDCB_BK_IDLE, SDCB_BK_ACTIVE};
  assign lo1 = o_bank1_state inside {SDCB_BK_IDLE, SDCB_BK_ACTIVE};
  act_bank0_a: assert property (nrm && $past(cke) && cke && cmd == SDCB_CMD_ACT && !addr[11]
    && o_bank0_state == SDCB_BK_IDLE && lo1 |=> o_bank0_state == SDCB_BK_ACTIVE
    && $stable(o_bank1_state)) else $error("bank0 activate wrong");
  act_bank1_a: assert property (nrm && $past(cke) && cke && cmd == SDCB_CMD_ACT && addr[11]
    && o_bank1_state == SDCB_BK_IDLE && lo0 |=> o_bank1_state == SDCB_BK_ACTIVE
    && $stable(o_bank0_state)) else $error("bank1 activate wrong");
  quiet_hold_a: assert property (nrm && $past(cke) && cke && (cs_n || cmd == SDCB_CMD_NOP)
    && lo0 && lo1 |=> $stable(o_bank0_state) && $stable(o_bank1_state))
    else $error("bank state moved on no-op");
  refresh_pulse_a: assert property (nrm && idl && $past(cke) && cke
    && cmd == SDCB_CMD_REF |=> o_refresh_pulse) else $error("no refresh pulse");
  mode_load_a: assert property (nrm && idl && $past(cke) && cke && cmd == SDCB_CMD_MRS
    |=> o_mode_reg == $past(addr)) else $error("mode register not loaded");
  sr_entry_a: assert property (nrm && idl && $fell(cke) && cmd == SDCB_CMD_REF
    |=> o_mode == SDCB_MD_SELF_REFRESH) else $error("self-refresh not entered");
  pd_entry_a: assert property (nrm && idl && $fell(cke) && cmd == SDCB_CMD_NOP
    |=> o_mode == SDCB_MD_POWER_DOWN) else $error("power-down not entered");
  sr_stay_a: assert property (o_mode == SDCB_MD_SELF_REFRESH |=> o_mode ==
    ($past(cke) ? SDCB_MD_SR_RECOVERY : SDCB_MD_SELF_REFRESH)) else $error("self-refresh exit");
  pd_stay_a: assert property (o_mode == SDCB_MD_POWER_DOWN |=> o_mode ==
    ($past(cke) ? SDCB_MD_NORMAL : SDCB_MD_POWER_DOWN)) else $error("power-down exit");
  susp_entry_a: assert property (nrm && !idl && $fell(cke)
    |=> o_mode == SDCB_MD_SUSPEND) else $error("suspend not entered");
  rec_pd_a: assert property (o_mode == SDCB_MD_SR_RECOVERY && $past(cke) && !cke
    && (cs_n || cmd == SDCB_CMD_NOP) |=> o_mode == SDCB_MD_POWER_DOWN)
    else $error("recovery power-down missed");
  susp_exit_a: assert property (o_mode == SDCB_MD_SUSPEND |=> o_mode ==
    ($past(cke) ? SDCB_MD_NORMAL : SDCB_MD_SUSPEND)) else $error("suspend exit");
  pre_all_a: assert property (nrm && $past(cke) && cke && cmd == SDCB_CMD_PRE && addr[10]
    && lo0 && lo1 |=> idl) else $error("precharge all left a bank open");
  read_ap_a: assert property (nrm && $past(cke) && cke && cmd == SDCB_CMD_READ && addr[10]
    && !addr[11] && o_bank0_state == SDCB_BK_ACTIVE |=> o_bank0_state == SDCB_BK_READ_AP)
    else $error("read auto-precharge state missing");
endmodule : sdcb_pins_sva

// file: sdcb_cke_and_bank_state_logic_tb.sv
// Testbench: controller and device joined through the pin interface.
// Assumes requests are taken when the controller is not busy.
`timescale 1ns/1ns
module sdcb_cke_and_bank_state_logic_tb;
  import sdcb_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_req = 4'h0;
  logic [11:0] i_addr = 12'h000;
  logic [11:0] o_mode_reg, a;
  logic [2:0] b0, b1, md, e0, e1;
  logic o_busy, o_frozen, o_illegal, o_refresh_pulse;
  int mismatches = 0, n_tests = 0, n_ref = 0, n_ill = 0, k, k0;
  sdcb_if pins_if ();
  sdcb_ctrl u_sdcb_ctrl (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(i_req),
    .i_addr(i_addr), .o_busy(o_busy), .pins(pins_if.ctrl));
  sdcb_device #(.BURST_CYC(SDCB_BURST_CYC)) u_sdcb_device (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .pins(pins_if.dev), .o_bank0_state(b0), .o_bank1_state(b1),
    .o_mode(md), .o_frozen(o_frozen), .o_illegal(o_illegal),
    .o_refresh_pulse(o_refresh_pulse), .o_mode_reg(o_mode_reg));
  sdcb_pins_sva u_sdcb_pins_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .cke(pins_if.cke),
    .cs_n(pins_if.cs_n), .ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n),
    .addr(pins_if.addr), .o_bank0_state(b0), .o_bank1_state(b1), .o_mode(md),
    .o_refresh_pulse(o_refresh_pulse), .o_mode_reg(o_mode_reg));
  initial begin
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    n_ref <= n_ref + ((o_refresh_pulse === 1'b1) ? 1 : 0);
    n_ill <= n_ill + ((o_illegal === 1'b1) ? 1 : 0);
  end
  task automatic tally_and_finish;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic step;
    @(posedge i_clk_sys);
    #1;
  endtask : step
  // Waits out busy except for a wake, holds the request one cycle, then allows the answer to land
  task automatic issue(input logic [3:0] rq, input logic [11:0] ad);
    k = 0;
    while (rq != SDCB_RQ_WAKE && o_busy !== 1'b0 && k < 40) begin
      step();
      k++;
    end
    i_req = rq;
    i_addr = ad;
    step();
    i_req = SDCB_RQ_NONE;
    repeat (2) step();
  endtask : issue
  function automatic logic [2:0] nxt(input logic [3:0] rq, input logic [11:0] ad,
                                     input logic bk, input logic [2:0] cur);
    if (rq == SDCB_RQ_PRE && (ad[SDCB_AP_BIT] || ad[SDCB_BANK_BIT] == bk)) return SDCB_BK_IDLE;
    if (ad[SDCB_BANK_BIT] != bk || cur == SDCB_BK_IDLE && rq != SDCB_RQ_ACT) return cur;
    case (rq)
      SDCB_RQ_ACT: return (cur == SDCB_BK_IDLE) ? SDCB_BK_ACTIVE : cur;
      SDCB_RQ_READ: return ad[SDCB_AP_BIT] ? SDCB_BK_READ_AP : SDCB_BK_READ;
      SDCB_RQ_WRITE: return ad[SDCB_AP_BIT] ? SDCB_BK_WRITE_AP : SDCB_BK_WRITE;
      SDCB_RQ_BST: return SDCB_BK_ACTIVE;
      default: return cur;
    endcase
  endfunction : nxt
  task automatic bank_op(input logic [3:0] rq, input logic [11:0] ad);
    e0 = nxt(rq, ad, 1'b0, b0);
    e1 = nxt(rq, ad, 1'b1, b1);
    issue(rq, ad);
    check({9'h0, b0}, {9'h0, e0});
    check({9'h0, b1}, {9'h0, e1});
  endtask : bank_op
  task automatic mode_is(input logic [2:0] exp);
    check({9'h0, md}, {9'h0, exp});
  endtask : mode_is
  initial begin
    #8000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'haba0));
    repeat (4) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b1;
    mode_is(SDCB_MD_NORMAL);
    a = 12'($urandom());
    issue(SDCB_RQ_MRS, a);
    check(o_mode_reg, a);
    issue(SDCB_RQ_REF, 12'h000);
    check(12'(n_ref), 12'h001);
    $display("test idle decode done");
    repeat (12) begin
      bank_op(SDCB_RQ_ACT, 12'($urandom()));
      bank_op(SDCB_RQ_PRE, 12'($urandom()));
    end
    bank_op(SDCB_RQ_PRE, 12'h400);
    $display("test random activate done");
    k0 = n_ill;
    bank_op(SDCB_RQ_READ, 12'h000);
    bank_op(SDCB_RQ_ACT, 12'h000);
    bank_op(SDCB_RQ_ACT, 12'h800);
    bank_op(SDCB_RQ_WRITE, 12'h800);
    bank_op(SDCB_RQ_BST, 12'h800);
    bank_op(SDCB_RQ_READ, 12'h400);
    k = 0;
    while (b0 !== SDCB_BK_IDLE && k < 20) begin
      step();
      k++;
    end
    check({11'h0, k <= SDCB_BURST_CYC + 2}, 12'h001);
    check(12'(n_ill - k0), 12'h001);
    $display("test bank commands done");
    issue(SDCB_RQ_SUSPEND, 12'h000);
    mode_is(SDCB_MD_SUSPEND);
    check({11'h0, o_frozen}, 12'h001);
    issue(SDCB_RQ_WAKE, 12'h000);
    mode_is(SDCB_MD_NORMAL);
    check({11'h0, o_frozen}, 12'h000);
    bank_op(SDCB_RQ_PRE, 12'h400);
    issue(SDCB_RQ_POWER_DOWN, 12'h000);
    mode_is(SDCB_MD_POWER_DOWN);
    check({11'h0, o_frozen}, 12'h001);
    issue(SDCB_RQ_WAKE, 12'h000);
    mode_is(SDCB_MD_NORMAL);
    $display("test suspend and power-down done");
    issue(SDCB_RQ_SELF_REFRESH, 12'h000);
    mode_is(SDCB_MD_SELF_REFRESH);
    repeat (5) step();
    mode_is(SDCB_MD_SELF_REFRESH);
    issue(SDCB_RQ_WAKE, 12'h000);
    mode_is(SDCB_MD_SR_RECOVERY);
    k = 0;
    while (md !== SDCB_MD_NORMAL && k < 40) begin
      step();
      k++;
    end
    check({11'h0, k + 4 >= SDCB_ROW_CYCLE_CYC && k <= SDCB_ROW_CYCLE_CYC}, 12'h001);
    bank_op(SDCB_RQ_ACT, 12'($urandom()));
    $display("test self-refresh done");
    tally_and_finish();
  end
endmodule : sdcb_cke_and_bank_state_logic_tb
